// *** ucp_cmd_port.sv ***
// Notes on behaviour
// [R1] Interrupt pin asserts whenever attention is needed
// [R2] Answer command and data seven-bit addresses
// [R3] Transaction lasts until stop or repeated start
// [R4] Command address is write only, read refused
// [R5] Many acked command bytes, forwarded to manager
// [R6] Data write bytes acked and forwarded
// [R7] Data read: send until master does not ack
// [R8] Serial clock up to 1 MHz, master driven
// [R9] Shared codes split by data phase direction
// [R10] D1h sets address and function enable
// [R11] D8h sets endpoint enable, gated by function
// [R12] F3h writes configuration then division factor
// [R13] Divided clock runs at reference over N+1
// [R14] Glitch-free factor change, kept over bus reset
// [R15] F4h reads interrupt bytes; endpoint status clears
// [R16] Bus reset sets byte two bit six
// [R17] Bus reset equals hardware reset plus interrupt, but keeps division factor and port enable
// [R18] Select endpoint resets pointer, reads full flag
// [R19] Per-endpoint codes are base plus index
// [R20] Accept acknowledge setup, clear, validate buffer
// [R21] Accept send resume and frame number read
// [R22] Buffer byte advances pointer; command keeps it
// [R23] Unknown command acked and otherwise ignored
`timescale 1ns/10ps
`default_nettype none
module ucp_cmd_port
  import ucp_pkg::*;
#(
  parameter int NUM_EP = UCP_NUM_EP
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_int_n,
  input wire logic i_usb_bus_rst,
  input wire logic [NUM_EP-1:0] i_ep_event,
  input wire logic [NUM_EP-1:0] i_ep_full,
  input wire logic [7:0] i_bm_rd_data,
  output ucp_bm_s o_bm,
  output logic [6:0] o_usb_addr,
  output logic o_fn_en,
  output logic o_ep_en,
  output logic [7:0] o_cfg,
  output logic o_divided_clock_output,
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);

  if (NUM_EP != UCP_NUM_EP) begin : g_bad_num_ep
    $error("ucp_cmd_port: NUM_EP must be 14");
  end
  if (UCP_SCL_MIN_CYC < 8) begin : g_slow_sys_clk
    $error("ucp_cmd_port: system clock too slow for serial bus");
  end

  // [R19] Base plus index decode
  function automatic logic in_range(input logic [7:0] b, input logic [7:0] base);
    return (b[7:4] == base[7:4]) && (b[3:0] <= UCP_EP_LAST);
  endfunction : in_range

  // [R20] Defined command set
  function automatic logic cmd_known(input logic [7:0] b);
    return in_range(b, UCP_BASE_SEL) || in_range(b, UCP_BASE_TSTAT) || in_range(b, UCP_BASE_EPSTAT) ||
      (b == UCP_CMD_SET_ADDR) || (b == UCP_CMD_SET_EPEN) || (b == UCP_CMD_SET_MODE) ||
      (b == UCP_CMD_RD_INT) || (b == UCP_CMD_BUF) || (b == UCP_CMD_ACK_SETUP) ||
      (b == UCP_CMD_CLR_BUF) || (b == UCP_CMD_VAL_BUF) || (b == UCP_CMD_RESUME) || (b == UCP_CMD_FRAME);
  endfunction : cmd_known

  ucp_state_e state_q;
  logic scl_q, sda_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic is_data_q, is_rd_q, mack_q;
  logic port_en_q;
  logic [7:0] cur_cmd_q, idx_q, ptr_q, cfg_q, div_q, div_act_q, dcnt_q;
  logic [3:0] sel_q;
  logic [6:0] addr_q;
  logic fn_en_q, ep_en_q;
  logic [15:0] int_q;
  logic [7:0] tx_byte;
  logic scl_rise, scl_fall, start_c, stop_c, byte_end;
  logic adr_cmd, adr_dat, rx_done, rx_cmd, rx_wr, tx_fetch, srst;

  ////////////////////////////////////////////////////////////////////////////
  // Serial line events

  assign srst = i_usb_bus_rst;
  assign scl_rise = i_scl & ~scl_q;
  assign scl_fall = ~i_scl & scl_q;
  // [R3] Start and stop detect
  assign start_c = scl_q & i_scl & sda_q & ~i_sda;
  assign stop_c = scl_q & i_scl & ~sda_q & i_sda;
  assign byte_end = scl_fall && (cnt_q == 4'h8);
  // [R2] Address match
  assign adr_cmd = (sh_q[7:1] == UCP_ADDR_CMD) && !sh_q[0];
  assign adr_dat = (sh_q[7:1] == UCP_ADDR_DAT);
  assign rx_done = (state_q == UCP_ST_RX) && byte_end;
  assign rx_cmd = rx_done && !is_data_q;
  assign rx_wr = rx_done && is_data_q;
  assign tx_fetch = scl_fall && (((state_q == UCP_ST_ACK) && is_rd_q) || ((state_q == UCP_ST_TXA) && mack_q));

  // [R8] Lines sampled at system rate, at least 20 samples per bit
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave state machine

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= UCP_ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      o_sda_oe <= 1'b0;
      is_data_q <= 1'b0;
      is_rd_q <= 1'b0;
      mack_q <= 1'b0;
    end else if (srst || stop_c) begin
      state_q <= UCP_ST_IDLE;
      o_sda_oe <= 1'b0;
    end else if (start_c) begin
      // [R3] Repeated start begins a fresh transaction
      state_q <= UCP_ST_ADDR;
      cnt_q <= 4'h0;
      o_sda_oe <= 1'b0;
    end else begin
      unique case (state_q)
        UCP_ST_IDLE: begin
        end
        UCP_ST_ADDR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], i_sda};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_end) begin
            // [R4] Read on command address left unacknowledged
            if (port_en_q && (adr_cmd || adr_dat)) begin
              state_q <= UCP_ST_ACK;
              o_sda_oe <= 1'b1;
              is_data_q <= adr_dat;
              is_rd_q <= adr_dat & sh_q[0];
            end else begin
              state_q <= UCP_ST_IDLE;
            end
          end
        end
        UCP_ST_ACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (is_rd_q) begin
              // [R7] First read byte driven after address ack
              state_q <= UCP_ST_TX;
              sh_q <= tx_byte;
              o_sda_oe <= ~tx_byte[7];
            end else begin
              state_q <= UCP_ST_RX;
              o_sda_oe <= 1'b0;
            end
          end
        end
        UCP_ST_RX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], i_sda};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_end) begin
            // [R5] Every received byte acknowledged
            state_q <= UCP_ST_ACK;
            o_sda_oe <= 1'b1;
          end
        end
        UCP_ST_TX: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              state_q <= UCP_ST_TXA;
              o_sda_oe <= 1'b0;
              mack_q <= 1'b0;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              o_sda_oe <= ~sh_q[6];
            end
          end
        end
        UCP_ST_TXA: begin
          if (scl_rise) begin
            // [R7] No ack from master ends the read, line released
            if (i_sda) begin
              state_q <= UCP_ST_IDLE;
            end else begin
              mack_q <= 1'b1;
            end
          end else if (scl_fall && mack_q) begin
            state_q <= UCP_ST_TX;
            cnt_q <= 4'h0;
            sh_q <= tx_byte;
            o_sda_oe <= ~tx_byte[7];
          end
        end
      endcase
    end
  end

  // Open drain: only the enable moves
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sda_out <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection

  // [R9] Shared codes resolved by read direction here
  always_comb begin
    tx_byte = 8'h00;
    if (cur_cmd_q == UCP_CMD_RD_INT) begin
      // [R15] Two interrupt bytes
      if (idx_q == 8'h00) begin
        tx_byte = int_q[7:0];
      end else if (idx_q == 8'h01) begin
        tx_byte = int_q[15:8];
      end
    end else if (in_range(cur_cmd_q, UCP_BASE_SEL)) begin
      // [R18] Full flag of selected buffer
      tx_byte = {7'h00, i_ep_full[sel_q]};
    end else if (in_range(cur_cmd_q, UCP_BASE_TSTAT) || in_range(cur_cmd_q, UCP_BASE_EPSTAT) ||
                 (cur_cmd_q == UCP_CMD_BUF) || (cur_cmd_q == UCP_CMD_FRAME)) begin
      // [R21] Frame number and status bytes from the manager
      tx_byte = i_bm_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command context and buffer pointer

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_cmd_q <= UCP_CMD_NONE;
      idx_q <= 8'h00;
      sel_q <= 4'h0;
      ptr_q <= 8'h00;
    end else if (srst) begin
      // [R17] Bus reset clears as the reset pin does
      cur_cmd_q <= UCP_CMD_NONE;
      idx_q <= 8'h00;
      sel_q <= 4'h0;
      ptr_q <= 8'h00;
    end else if (rx_cmd) begin
      // [R23] Unknown codes leave context untouched
      if (cmd_known(sh_q)) begin
        cur_cmd_q <= sh_q;
        idx_q <= 8'h00;
        // [R18] Select resets pointer
        if (in_range(sh_q, UCP_BASE_SEL)) begin
          sel_q <= sh_q[3:0];
          ptr_q <= 8'h00;
        end
      end
    end else if (rx_wr || tx_fetch) begin
      idx_q <= idx_q + 8'h01;
      // [R22] Each buffer byte advances pointer
      if (cur_cmd_q == UCP_CMD_BUF) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Initialization settings

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_q <= 7'h00;
      fn_en_q <= 1'b0;
      ep_en_q <= 1'b0;
      cfg_q <= UCP_CFG_RESET;
    end else if (srst) begin
      addr_q <= 7'h00;
      fn_en_q <= 1'b0;
      ep_en_q <= 1'b0;
      cfg_q <= UCP_CFG_RESET;
    end else if (rx_wr) begin
      // [R10] Address and function enable
      if (cur_cmd_q == UCP_CMD_SET_ADDR) begin
        addr_q <= sh_q[6:0];
        fn_en_q <= sh_q[UCP_ADDR_EN_BIT];
      end
      // [R11] Generic endpoint enable
      if (cur_cmd_q == UCP_CMD_SET_EPEN) begin
        ep_en_q <= sh_q[UCP_EPEN_BIT];
      end
      // [R12] First mode byte is configuration
      if ((cur_cmd_q == UCP_CMD_SET_MODE) && (idx_q == 8'h00)) begin
        cfg_q <= sh_q;
      end
    end
  end

  // [R14] Factor survives a bus reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= UCP_DIV_RESET;
    end else if (rx_wr && (cur_cmd_q == UCP_CMD_SET_MODE) && (idx_q == 8'h01)) begin
      // [R13] Factor never below the minimum
      div_q <= (sh_q < UCP_DIV_MIN) ? UCP_DIV_MIN : sh_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divided clock

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dcnt_q <= 8'h00;
      div_act_q <= UCP_DIV_RESET;
      o_divided_clock_output <= 1'b0;
    end else begin
      // [R14] New factor adopted only at period end
      if (dcnt_q >= div_act_q) begin
        dcnt_q <= 8'h00;
        div_act_q <= div_q;
      end else begin
        dcnt_q <= dcnt_q + 8'h01;
      end
      // [R13] High for first half of N+1 cycles
      o_divided_clock_output <= (dcnt_q >= div_act_q) || (dcnt_q < (div_act_q >> 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt register

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_q <= 16'h0000;
    end else if (srst) begin
      // [R16] Bus reset notification
      int_q <= 16'h0000;
      int_q[UCP_INT_BUSRST_BIT] <= 1'b1;
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        // [R15] Endpoint status read clears; new event wins
        if (i_ep_event[i]) begin
          int_q[i] <= 1'b1;
        end else if (tx_fetch && in_range(cur_cmd_q, UCP_BASE_EPSTAT) && (cur_cmd_q[3:0] == 4'(i))) begin
          int_q[i] <= 1'b0;
        end
      end
      // [R16] Reading the interrupt register clears the bus reset flag
      // Cleared only once the byte holding the flag is loaded
      if (tx_fetch && (cur_cmd_q == UCP_CMD_RD_INT) && (idx_q == 8'h01)) begin
        int_q[UCP_INT_BUSRST_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs towards the system

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bm <= '0;
      o_int_n <= 1'b1;
      o_usb_addr <= 7'h00;
      o_fn_en <= 1'b0;
      o_ep_en <= 1'b0;
      o_cfg <= UCP_CFG_RESET;
    end else begin
      // [R5] Known command bytes forwarded
      o_bm.cmd_vld <= rx_cmd && cmd_known(sh_q);
      // [R6] Data write bytes forwarded
      o_bm.wr_vld <= rx_wr;
      o_bm.rd_vld <= tx_fetch;
      o_bm.code <= rx_cmd ? sh_q : cur_cmd_q;
      o_bm.data <= rx_wr ? sh_q : tx_byte;
      o_bm.ep <= sel_q;
      o_bm.ptr <= ptr_q;
      // [R1] Attention while any flag stands
      o_int_n <= ~(|int_q);
      o_usb_addr <= addr_q;
      o_fn_en <= fn_en_q;
      // [R11] Endpoints live only with function on
      o_ep_en <= ep_en_q & fn_en_q;
      o_cfg <= cfg_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port_en_q <= UCP_CTRL_RESET;
    end else if (i_psel && i_penable && o_pready && i_pwrite && (i_paddr == UCP_REG_CTRL)) begin
      port_en_q <= i_pwdata[0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
      if (i_psel && !i_penable) begin
        unique case (i_paddr)
          UCP_REG_STATUS: o_prdata <= {22'h0, ep_en_q & fn_en_q, fn_en_q, 1'b0, addr_q};
          UCP_REG_INT: o_prdata <= {16'h0, int_q};
          UCP_REG_MODE: o_prdata <= {16'h0, div_q, cfg_q};
          UCP_REG_SEL: o_prdata <= {12'h0, sel_q, ptr_q, cur_cmd_q};
          UCP_REG_CTRL: o_prdata <= {31'h0, port_en_q};
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_cmd_read_nak: assert property ( // [R4]
    (state_q == UCP_ST_ADDR) && byte_end && (sh_q == {UCP_ADDR_CMD, 1'b1}) |=> !o_sda_oe && (state_q == UCP_ST_IDLE))
    else $error("read on command address was acknowledged");
  a_addr_ack: assert property ( // [R2]
    (state_q == UCP_ST_ADDR) && byte_end && port_en_q && (adr_cmd || adr_dat) |=> o_sda_oe [*1] ##0 (state_q == UCP_ST_ACK))
    else $error("matching address not acknowledged");
  a_stop_idle: assert property ( // [R3]
    stop_c && !srst |=> (state_q == UCP_ST_IDLE) && !o_sda_oe)
    else $error("transaction not ended by stop");
  a_int_pin: assert property ( // [R1]
    $rose(|int_q) |=> !o_int_n)
    else $error("interrupt pin not asserted");
  a_bus_rst_flag: assert property ( // [R16]
    srst |=> int_q[UCP_INT_BUSRST_BIT] && !fn_en_q ##1 !o_int_n)
    else $error("bus reset did not flag interrupt");
  a_div_keep: assert property ( // [R14]
    srst |=> $stable(div_q))
    else $error("bus reset changed division factor");
  a_div_min: assert property ( // [R13]
    div_q >= UCP_DIV_MIN)
    else $error("division factor below minimum");
  a_ep_gate: assert property ( // [R11]
    !fn_en_q |=> !o_ep_en)
    else $error("endpoints enabled with function off");
  a_sel_ptr: assert property ( // [R18]
    rx_cmd && in_range(sh_q, UCP_BASE_SEL) && !srst |=> (ptr_q == 8'h00) && (sel_q == $past(sh_q[3:0])))
    else $error("select endpoint did not reset pointer");
  a_buf_ptr: assert property ( // [R22]
    tx_fetch && (cur_cmd_q == UCP_CMD_BUF) && !srst |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("buffer read did not advance pointer");
  a_unknown_cmd: assert property ( // [R23]
    rx_cmd && !cmd_known(sh_q) && !srst |=> $stable(cur_cmd_q) && !o_bm.cmd_vld)
    else $error("unknown command changed state");

  c_cmd_write: cover property (rx_cmd && (sh_q == UCP_CMD_SET_ADDR));
  c_data_read: cover property (tx_fetch && (cur_cmd_q == UCP_CMD_RD_INT) ##[1:400] tx_fetch);
  c_master_nak: cover property ((state_q == UCP_ST_TXA) ##1 (state_q == UCP_ST_IDLE));
  c_bus_reset: cover property (srst ##1 !o_int_n);

endmodule : ucp_cmd_port
`default_nettype wire

// *** ucp_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ucp_host_model (
  input wire logic i_sys_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_pull
);
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  task automatic qwait(input int n);
    repeat (n * 5) @(posedge i_sys_clk);
  endtask : qwait
  task automatic bit_io(input logic b, output logic r);
    o_sda_pull <= ~b;
    qwait(1);
    o_scl <= 1'b1;
    qwait(1);
    r = i_sda;
    qwait(1);
    o_scl <= 1'b0;
    qwait(1);
  endtask : bit_io
  task automatic start();
    @(posedge i_sys_clk);
    o_sda_pull <= 1'b0;
    qwait(1);
    o_scl <= 1'b1;
    qwait(1);
    o_sda_pull <= 1'b1;
    qwait(1);
    o_scl <= 1'b0;
  endtask : start
  // byte, master acks only when mack is set
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(~mack, r);
    ack = ~r;
  endtask : xfer
  task automatic stop();
    o_sda_pull <= 1'b1;
    qwait(1);
    o_scl <= 1'b1;
    qwait(1);
    o_sda_pull <= 1'b0;
    qwait(2);
  endtask : stop
endmodule : ucp_host_model
`default_nettype wire

// *** ucp_pkg.sv ***
package ucp_pkg;
  // Serial slave addresses, seven bits
  localparam logic [6:0] UCP_ADDR_CMD = 7'h1b;
  localparam logic [6:0] UCP_ADDR_DAT = 7'h1a;
  // Command codes
  localparam logic [7:0] UCP_CMD_SET_ADDR = 8'hd1;
  localparam logic [7:0] UCP_CMD_SET_EPEN = 8'hd8;
  localparam logic [7:0] UCP_CMD_SET_MODE = 8'hf3;
  localparam logic [7:0] UCP_CMD_RD_INT = 8'hf4;
  localparam logic [7:0] UCP_CMD_BUF = 8'hf0;
  localparam logic [7:0] UCP_CMD_ACK_SETUP = 8'hf1;
  localparam logic [7:0] UCP_CMD_CLR_BUF = 8'hf2;
  localparam logic [7:0] UCP_CMD_VAL_BUF = 8'hfa;
  localparam logic [7:0] UCP_CMD_RESUME = 8'hf6;
  localparam logic [7:0] UCP_CMD_FRAME = 8'hf5;
  localparam logic [7:0] UCP_CMD_NONE = 8'hff;
  localparam logic [7:0] UCP_BASE_SEL = 8'h00;
  localparam logic [7:0] UCP_BASE_TSTAT = 8'h40;
  localparam logic [7:0] UCP_BASE_EPSTAT = 8'h80;
  localparam logic [3:0] UCP_EP_LAST = 4'hd;
  localparam int UCP_NUM_EP = 14;
  // Field positions
  localparam int UCP_ADDR_EN_BIT = 7;
  localparam int UCP_EPEN_BIT = 0;
  localparam int UCP_INT_BUSRST_BIT = 14;
  // Reset values and factor minimum
  localparam logic [7:0] UCP_DIV_RESET = 8'h0b;
  localparam logic [7:0] UCP_DIV_MIN = 8'h01;
  localparam logic [7:0] UCP_CFG_RESET = 8'h00;
  // Serial bit timing against the system clock
  localparam int UCP_SYS_CLK_NS = 50;
  localparam int UCP_SCL_MIN_PERIOD_NS = 1000;
  localparam int UCP_SCL_MIN_CYC = UCP_SCL_MIN_PERIOD_NS / UCP_SYS_CLK_NS;
  // APB register byte offsets and control reset value
  localparam logic [7:0] UCP_REG_STATUS = 8'h00;
  localparam logic [7:0] UCP_REG_INT = 8'h04;
  localparam logic [7:0] UCP_REG_MODE = 8'h08;
  localparam logic [7:0] UCP_REG_SEL = 8'h0c;
  localparam logic [7:0] UCP_REG_CTRL = 8'h10;
  localparam logic UCP_CTRL_RESET = 1'b1;

  typedef enum logic [5:0] {
    UCP_ST_IDLE = 6'b000001,
    UCP_ST_ADDR = 6'b000010,
    UCP_ST_ACK = 6'b000100,
    UCP_ST_RX = 6'b001000,
    UCP_ST_TX = 6'b010000,
    UCP_ST_TXA = 6'b100000
  } ucp_state_e;

  // Strobes and data towards the buffer manager
  typedef struct packed {
    logic cmd_vld;
    logic wr_vld;
    logic rd_vld;
    logic [7:0] code;
    logic [7:0] data;
    logic [3:0] ep;
    logic [7:0] ptr;
  } ucp_bm_s;
endpackage : ucp_pkg

// *** usb_device_serial_command_port_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module usb_device_serial_command_port_tb
  import ucp_pkg::*;
;
  logic clk, rst_n, bus_rst, psel, penable, pwrite, sda_out, sda_oe, int_n, dco;
  logic pready, pslverr, fn_en, ep_en, scl, pull, ack, err;
  logic [13:0] ev, full;
  logic [7:0] paddr, rx, cfg;
  logic [31:0] pwdata, prdata, r;
  logic [6:0] uaddr;
  ucp_bm_s bm;
  wire logic sda = ~((sda_oe & ~sda_out) | pull);
  wire logic [7:0] bm_rd = bm.ptr ^ 8'h3c;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  ucp_cmd_port ucp_cmd_port_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_int_n(int_n), .i_usb_bus_rst(bus_rst), .i_ep_event(ev),
    .i_ep_full(full), .i_bm_rd_data(bm_rd), .o_bm(bm), .o_usb_addr(uaddr), .o_fn_en(fn_en),
    .o_ep_en(ep_en), .o_cfg(cfg), .o_divided_clock_output(dco), .i_paddr(paddr), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr));
  ucp_host_model ucp_host_model_inst (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(r, exp);
  endtask : rd
  task automatic send(input logic [7:0] b, input logic exp_ack);
    ucp_host_model_inst.xfer(b, 1'b0, rx, ack);
    check({31'h0, ack}, {31'h0, exp_ack});
  endtask : send
  task automatic recv(input logic mack, input logic [7:0] exp);
    ucp_host_model_inst.xfer(8'hff, mack, rx, ack);
    check({24'h0, rx}, {24'h0, exp});
  endtask : recv
  task automatic addr_phase(input logic [7:0] a, input logic exp_ack);
    ucp_host_model_inst.start();
    send(a, exp_ack);
  endtask : addr_phase
  task automatic cmd(input logic [7:0] c);
    addr_phase({UCP_ADDR_CMD, 1'b0}, 1'b1);
    send(c, 1'b1);
    ucp_host_model_inst.stop();
  endtask : cmd
  task automatic period(input int exp);
    int n;
    logic p;
    @(posedge dco);
    @(negedge clk);
    n = 0;
    p = 1'b1;
    while (!(p === 1'b0 && dco === 1'b1)) begin
      p = dco;
      @(negedge clk);
      n++;
    end
    check(32'(n), 32'(exp));
  endtask : period
  task automatic pulse_wait(input logic b, input logic [13:0] e);
    @(posedge clk);
    bus_rst <= b;
    ev <= e;
    @(posedge clk);
    bus_rst <= 1'b0;
    ev <= 14'h0;
    repeat (3) @(posedge clk);
  endtask : pulse_wait
  ////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {bus_rst, psel, penable, pwrite, paddr, pwdata, ev} = '0;
    full = 14'h0008;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    check({31'h0, int_n}, 32'h1);
    rd(UCP_REG_STATUS, 32'h0);
    rd(UCP_REG_MODE, 32'h0000_0b00);
    rd(8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(UCP_REG_CTRL, 1'b1, 32'h0);
    addr_phase({UCP_ADDR_CMD, 1'b0}, 1'b0);
    ucp_host_model_inst.stop();
    apb(UCP_REG_CTRL, 1'b1, 32'h1);
    rd(UCP_REG_CTRL, 32'h1);
    addr_phase(8'h44, 1'b0);
    ucp_host_model_inst.stop();
    addr_phase({UCP_ADDR_CMD, 1'b1}, 1'b0);
    ucp_host_model_inst.stop();
    $display("test addressing done");
    cmd(UCP_CMD_SET_EPEN);
    addr_phase({UCP_ADDR_DAT, 1'b0}, 1'b1);
    send(8'h01, 1'b1);
    ucp_host_model_inst.stop();
    check({31'h0, ep_en}, 32'h0);
    cmd(UCP_CMD_SET_ADDR);
    addr_phase({UCP_ADDR_DAT, 1'b0}, 1'b1);
    send(8'h85, 1'b1);
    ucp_host_model_inst.stop();
    check({22'h0, ep_en, fn_en, 1'b0, uaddr}, 32'h305);
    rd(UCP_REG_STATUS, 32'h305);
    addr_phase({UCP_ADDR_CMD, 1'b0}, 1'b1);
    send(UCP_CMD_RESUME, 1'b1);
    send(UCP_CMD_ACK_SETUP, 1'b1);
    send(UCP_CMD_CLR_BUF, 1'b1);
    send(UCP_CMD_VAL_BUF, 1'b1);
    send(UCP_CMD_FRAME, 1'b1);
    addr_phase({UCP_ADDR_DAT, 1'b1}, 1'b1);
    recv(1'b0, 8'h3c);
    ucp_host_model_inst.stop();
    $display("test init done");
    cmd(UCP_CMD_SET_MODE);
    addr_phase({UCP_ADDR_DAT, 1'b0}, 1'b1);
    send(8'h5a, 1'b1);
    send(8'h00, 1'b1);
    ucp_host_model_inst.stop();
    rd(UCP_REG_MODE, 32'h015a);
    period(2);
    cmd(UCP_CMD_SET_MODE);
    addr_phase({UCP_ADDR_DAT, 1'b0}, 1'b1);
    send(8'h5a, 1'b1);
    send(8'h03, 1'b1);
    ucp_host_model_inst.stop();
    repeat (10) @(posedge clk);
    period(4);
    $display("test clock done");
    pulse_wait(1'b1, 14'h0);
    check({31'h0, int_n}, 32'h0);
    check({16'h0, fn_en, cfg, uaddr}, 32'h0);
    rd(UCP_REG_MODE, 32'h0300);
    cmd(UCP_CMD_RD_INT);
    addr_phase({UCP_ADDR_DAT, 1'b1}, 1'b1);
    recv(1'b1, 8'h00);
    recv(1'b0, 8'h40);
    ucp_host_model_inst.stop();
    check({31'h0, int_n}, 32'h1);
    pulse_wait(1'b0, 14'h0004);
    check({31'h0, int_n}, 32'h0);
    cmd(UCP_CMD_RD_INT);
    addr_phase({UCP_ADDR_DAT, 1'b1}, 1'b1);
    recv(1'b1, 8'h04);
    recv(1'b0, 8'h00);
    ucp_host_model_inst.stop();
    check({31'h0, int_n}, 32'h0);
    cmd(UCP_BASE_EPSTAT + 8'h02);
    addr_phase({UCP_ADDR_DAT, 1'b1}, 1'b1);
    recv(1'b0, 8'h3c);
    ucp_host_model_inst.stop();
    repeat (3) @(posedge clk);
    check({31'h0, int_n}, 32'h1);
    $display("test interrupts done");
    for (int e = 3; e < 5; e++) begin
      cmd(UCP_BASE_SEL + 8'(e));
      addr_phase({UCP_ADDR_DAT, 1'b1}, 1'b1);
      recv(1'b0, (e == 3) ? 8'h01 : 8'h00);
      ucp_host_model_inst.stop();
    end
    cmd(UCP_CMD_BUF);
    addr_phase({UCP_ADDR_DAT, 1'b0}, 1'b1);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    send(8'h33, 1'b1);
    ucp_host_model_inst.stop();
    rd(UCP_REG_SEL, 32'h000403f0);
    addr_phase({UCP_ADDR_CMD, 1'b0}, 1'b1);
    send(UCP_CMD_BUF, 1'b1);
    addr_phase({UCP_ADDR_DAT, 1'b1}, 1'b1);
    recv(1'b1, 8'h3f);
    recv(1'b0, 8'h38);
    ucp_host_model_inst.stop();
    rd(UCP_REG_SEL, 32'h000405f0);
    cmd(8'he0);
    rd(UCP_REG_SEL, 32'h000405f0);
    cmd(UCP_BASE_SEL + 8'h04);
    rd(UCP_REG_SEL, 32'h00040004);
    $display("test buffer done");
    give_verdict();
  end
endmodule : usb_device_serial_command_port_tb
`default_nettype wire
